// ---- pkg/slope_adc_pkg.sv ----
// Constants and types for the slope converter sequencer
package slope_adc_pkg;

    // Timing
    localparam int  CLK_HZ          = 25_000_000;
    localparam int  TIMEBASE_HZ     = 20_000_000;
    localparam int  RAMP_PERIOD_US  = 100_000;
    localparam int  RESET_PULSE_US  = 10_000;
    localparam int  SELECT_GAP_NS   = 1_000;
    localparam int  RAMP_PERIOD_CYC = RAMP_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam int  RESET_PULSE_CYC = RESET_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int  SELECT_GAP_CYC  = (SELECT_GAP_NS * (CLK_HZ / 1_000_000)
                                       + 999) / 1_000;

    // Arithmetic
    localparam int  COUNT_W         = 24;
    localparam int  RESULT_W        = 32;
    localparam int  SCALE_K         = 10;
    localparam int  AVG_DEFAULT     = 4;

    // AXI4-Lite register map
    localparam logic [4:0] CTRL_OFS   = 5'h00;
    localparam logic [4:0] STATUS_OFS = 5'h04;
    localparam logic [4:0] RESULT_OFS = 5'h08;
    localparam logic [4:0] ZERO_OFS   = 5'h0c;
    localparam logic [4:0] FULL_OFS   = 5'h10;
    localparam logic [4:0] UNK_OFS    = 5'h14;
    localparam logic [4:0] AVG_OFS    = 5'h18;
    localparam logic [7:0] AVG_RESET  = 8'h01;
    localparam logic [1:0] RESP_OKAY  = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Source select codes, one-hot except SEL_NONE, which is all zero
    localparam logic [2:0] SEL_NONE = 3'b000;
    localparam logic [2:0] SEL_ZERO = 3'b001;
    localparam logic [2:0] SEL_FULL = 3'b010;
    localparam logic [2:0] SEL_UNK  = 3'b100;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_GAP    = 3'b001,
        ST_WAIT   = 3'b010,
        ST_COUNT  = 3'b011,
        ST_DIVIDE = 3'b100,
        ST_DONE   = 3'b101
    } seq_state_t;

endpackage

// ---- logic/ratio_divider.sv ----
// Serial restoring divider for the ratiometric result
`timescale 1ns/1ps
module ratio_divider
    import slope_adc_pkg::*;
#(
    parameter int W = RESULT_W
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         start,
    input  wire logic [W-1:0] dividend,
    input  wire logic [W-1:0] divisor,
    output logic              done,
    output logic [W-1:0]      quotient
);

    logic [W-1:0]         rem_q;
    logic [W-1:0]         quo_q;
    logic [$clog2(W+1)-1:0] cnt_q;
    logic                 busy_q;
    logic [W:0]           trial;
    logic [W:0]           shifted;

    assign shifted = {rem_q, quo_q[W-1]};
    assign trial   = shifted - {1'b0, divisor};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rem_q    <= '0;
            quo_q    <= '0;
            cnt_q    <= '0;
            busy_q   <= 1'b0;
            done     <= 1'b0;
            quotient <= '0;
        end else begin
            done <= 1'b0;
            if (start) begin
                rem_q  <= '0;
                quo_q  <= dividend;
                cnt_q  <= ($clog2(W+1))'(W);
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (!trial[W]) begin
                    rem_q <= trial[W-1:0];
                    quo_q <= {quo_q[W-2:0], 1'b1};
                end else begin
                    rem_q <= shifted[W-1:0];
                    quo_q <= {quo_q[W-2:0], 1'b0};
                end
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q == 1) begin
                    busy_q <= 1'b0;
                    done   <= 1'b1;
                    quotient <= (divisor == '0) ? '1 :
                                (!trial[W] ? {quo_q[W-2:0], 1'b1}
                                           : {quo_q[W-2:0], 1'b0});
                end
            end
        end
    end

endmodule // ratio_divider

// ---- logic/slope_adc_seq.sv ----
// Sequencer for a calibrated single-slope integrating converter
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module slope_adc_seq
    import slope_adc_pkg::*;
#(
    parameter int RAMP_CYC  = RAMP_PERIOD_CYC,
    parameter int RESET_CYC = RESET_PULSE_CYC,
    parameter int AVG_N     = AVG_DEFAULT
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        convert,
    output logic             busy,
    output logic             result_valid,
    output logic [31:0]      result,
    output logic             integ_reset,
    output logic [2:0]       source_sel,
    input  wire logic        width_in
);

    ////////////////////////////////////////////////////////////////////
    // Ramp timebase

    logic [31:0] ramp_cnt_q;
    logic        ramp_start;
    logic        integ_reset_d;

    assign ramp_start    = (ramp_cnt_q == 32'(RESET_CYC));
    assign integ_reset_d = (ramp_cnt_q < 32'(RESET_CYC));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ramp_cnt_q  <= '0;
            integ_reset <= 1'b1;
        end else begin
            ramp_cnt_q  <= (ramp_cnt_q == 32'(RAMP_CYC - 1)) ? '0
                                                            : ramp_cnt_q + 1;
            integ_reset <= integ_reset_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Width input synchroniser

    logic width_m_q;
    logic width_s_q;
    logic width_p_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            width_m_q <= 1'b0;
            width_s_q <= 1'b0;
            width_p_q <= 1'b0;
        end else begin
            width_m_q <= width_in;
            width_s_q <= width_m_q;
            width_p_q <= width_s_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register bus

    logic [7:0]  avg_q;
    logic        sw_convert_q;
    logic        aw_held_q;
    logic        w_held_q;
    logic [4:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        do_write;
    logic        avg_hit;
    logic        ctrl_hit;
    logic        rd_hit;
    logic [31:0] rd_mux;
    logic [COUNT_W-1:0] zero_q;
    logic [COUNT_W-1:0] full_q;
    logic [COUNT_W-1:0] unk_q;

    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;
    assign ctrl_hit      = (awaddr_q == CTRL_OFS);
    assign avg_hit       = (awaddr_q == AVG_OFS);
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_hit        = (s_axi_araddr == CTRL_OFS)
                        || (s_axi_araddr == STATUS_OFS)
                        || (s_axi_araddr == RESULT_OFS)
                        || (s_axi_araddr == ZERO_OFS)
                        || (s_axi_araddr == FULL_OFS)
                        || (s_axi_araddr == UNK_OFS)
                        || (s_axi_araddr == AVG_OFS);
    assign rd_mux = (s_axi_araddr == STATUS_OFS) ? {30'h0, result_valid, busy}
                  : (s_axi_araddr == RESULT_OFS) ? result
                  : (s_axi_araddr == ZERO_OFS)   ? 32'(zero_q)
                  : (s_axi_araddr == FULL_OFS)   ? 32'(full_q)
                  : (s_axi_araddr == UNK_OFS)    ? 32'(unk_q)
                  : (s_axi_araddr == AVG_OFS)    ? {24'h0, avg_q}
                  : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            awaddr_q     <= '0;
            wdata_q      <= '0;
            wstrb_q      <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            avg_q        <= 8'(AVG_N);
            sw_convert_q <= 1'b0;
        end else begin
            sw_convert_q <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (ctrl_hit || avg_hit) ? RESP_OKAY
                                                      : RESP_SLVERR;
                if (avg_hit && wstrb_q[0]) begin
                    avg_q <= (wdata_q[7:0] == 8'h00) ? AVG_RESET
                                                     : wdata_q[7:0];
                end
                if (ctrl_hit && wstrb_q[0] && wdata_q[0]) begin
                    sw_convert_q <= 1'b1;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Conversion sequencer

    seq_state_t             state_q;
    logic [1:0]             phase_q;
    logic [7:0]             pass_q;
    logic [7:0]             gap_q;
    logic [COUNT_W-1:0]     count_q;
    logic [RESULT_W-1:0]    acc_q;
    logic                   start_cmd;
    logic                   div_start;
    logic                   div_done;
    logic [RESULT_W-1:0]    quotient;
    logic [RESULT_W-1:0]    numer;
    logic [RESULT_W-1:0]    denom;
    logic [2:0]             phase_sel;
    logic                   crossed;

    assign start_cmd = (convert || sw_convert_q) && (state_q == ST_IDLE);
    assign busy      = (state_q != ST_IDLE);
    // Falling edge of gated width only
    assign crossed   = width_p_q && !width_s_q;
    assign phase_sel = (phase_q == 2'd0) ? SEL_ZERO
                     : (phase_q == 2'd1) ? SEL_FULL : SEL_UNK;
    assign numer = RESULT_W'((unk_q > zero_q) ? (unk_q - zero_q) : '0)
                 * RESULT_W'(SCALE_K);
    assign denom = RESULT_W'((full_q > zero_q) ? (full_q - zero_q) : '0);
    assign div_start = (state_q == ST_COUNT) && crossed && (phase_q == 2'd2);

    ratio_divider #(
        .W        (RESULT_W)
    ) u_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .start    (state_q == ST_DIVIDE && gap_q == 8'h00),
        .dividend (numer),
        .divisor  (denom),
        .done     (div_done),
        .quotient (quotient)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q      <= ST_IDLE;
            phase_q      <= '0;
            pass_q       <= '0;
            gap_q        <= '0;
            count_q      <= '0;
            acc_q        <= '0;
            zero_q       <= '0;
            full_q       <= '0;
            unk_q        <= '0;
            result       <= '0;
            result_valid <= 1'b0;
            source_sel   <= SEL_NONE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_cmd) begin
                        phase_q      <= 2'd0;
                        pass_q       <= '0;
                        acc_q        <= '0;
                        gap_q        <= 8'(SELECT_GAP_CYC);
                        result_valid <= 1'b0;
                        source_sel   <= SEL_NONE;
                        state_q      <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (gap_q == 8'h00) begin
                        source_sel <= phase_sel;
                        state_q    <= ST_WAIT;
                    end else begin
                        gap_q <= gap_q - 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (ramp_start) begin
                        count_q <= '0;
                        state_q <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (crossed || ramp_start) begin
                        case (phase_q)
                            2'd0:    zero_q <= count_q;
                            2'd1:    full_q <= count_q;
                            default: unk_q  <= count_q;
                        endcase
                        source_sel <= SEL_NONE;
                        gap_q      <= 8'(SELECT_GAP_CYC);
                        if (phase_q == 2'd2) begin
                            gap_q   <= 8'h00;
                            state_q <= ST_DIVIDE;
                        end else begin
                            phase_q <= phase_q + 1'b1;
                            state_q <= ST_GAP;
                        end
                    end else begin
                        count_q <= count_q + 1'b1;
                    end
                end
                ST_DIVIDE: begin
                    gap_q <= 8'h01;
                    if (div_done) begin
                        acc_q  <= acc_q + quotient;
                        pass_q <= pass_q + 1'b1;
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (pass_q >= avg_q) begin
                        result       <= acc_q / RESULT_W'(avg_q);
                        result_valid <= 1'b1;
                        state_q      <= ST_IDLE;
                    end else begin
                        phase_q <= 2'd0;
                        gap_q   <= 8'(SELECT_GAP_CYC);
                        state_q <= ST_GAP;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    logic unused_ok;
    assign unused_ok = div_start;

endmodule // slope_adc_seq

// ---- bench/slope_adc_seq_sva.sv ----
// Checker for the slope converter sequencer
`timescale 1ns/1ps
module slope_adc_seq_chk
    import slope_adc_pkg::*;
#(
    parameter int RAMP_CYC  = RAMP_PERIOD_CYC,
    parameter int RESET_CYC = RESET_PULSE_CYC
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        convert,
    input wire logic        busy,
    input wire logic        result_valid,
    input wire logic [31:0] result,
    input wire logic        integ_reset,
    input wire logic [2:0]  source_sel
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [31:0] hi_q;
    logic [31:0] lo_q;
    logic        seen_q;
    logic [2:0]  last_q;
    ////////////////////////////////////////////////////////////////////////
    // Run lengths of the reset pulse, last source used
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hi_q   <= 32'h0;
            lo_q   <= 32'h0;
            seen_q <= 1'b0;
            last_q <= SEL_NONE;
        end else begin
            hi_q   <= integ_reset ? hi_q + 32'h1 : 32'h0;
            lo_q   <= integ_reset ? 32'h0 : lo_q + 32'h1;
            seen_q <= seen_q | (integ_reset & (lo_q != 32'h0));
            if (!busy)
                last_q <= SEL_NONE;
            else if (source_sel != SEL_NONE)
                last_q <= source_sel;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sel_onehot_a: assert property ($onehot0(source_sel))
        else $error("several sources selected");
    break_make_a: assert property (
        source_sel != SEL_NONE && $changed(source_sel)
        |-> $past(source_sel) == SEL_NONE) else $error("no break");
    pulse_high_a: assert property (
        $fell(integ_reset) && seen_q |-> hi_q == RESET_CYC)
        else $error("reset pulse length wrong");
    pulse_low_a: assert property (
        $rose(integ_reset) && seen_q |-> lo_q == RAMP_CYC - RESET_CYC)
        else $error("reset pulse spacing wrong");
    src_order_a: assert property ($rose(|source_sel) |->
        {last_q, source_sel} inside {6'h01, 6'h0a, 6'h14, 6'h21})
        else $error("sources out of order");
    accept_a: assert property (
        !busy && convert |=> busy && !result_valid)
        else $error("command not taken");
    done_a: assert property ($fell(busy) |-> result_valid)
        else $error("busy ended without result");
    hold_a: assert property (
        result_valid && $past(result_valid) |-> $stable(result))
        else $error("result changed while presented");
    cover property ($rose(result_valid));
    cover property (busy && convert);
    cover property ($rose(source_sel == SEL_UNK));
endmodule // slope_adc_seq_chk
bind slope_adc_seq slope_adc_seq_chk #(
    .RAMP_CYC(RAMP_CYC), .RESET_CYC(RESET_CYC)
) chk (
    .aclk, .aresetn, .convert, .busy, .result_valid, .result,
    .integ_reset, .source_sel
);

// ---- bench/front_end_model.sv ----
// Behavioural model of the isolated analog front end
`timescale 1ns/1ps
module front_end_model
    import slope_adc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        integ_reset,
    input  wire logic [2:0]  source_sel,
    input  wire logic [15:0] unk_len,
    output logic             width_in
);
    logic [15:0] ramp_q;
    logic [15:0] len;
    ////////////////////////////////////////////////////////////////////////
    // Crossing time per source
    assign len = (source_sel == SEL_ZERO) ? 16'h28 :
                 (source_sel == SEL_FULL) ? 16'hf0 :
                 (source_sel == SEL_UNK)  ? unk_len : 16'h64;
    always_ff @(posedge aclk) begin
        if (!aresetn || integ_reset) begin
            ramp_q   <= 16'h0;
            width_in <= 1'b0;
        end else begin
            ramp_q   <= ramp_q + 16'h1;
            width_in <= ramp_q < len;
        end
    end
endmodule // front_end_model

// ---- bench/tb_slope_adc_seq.sv ----
// Testbench for the slope converter sequencer
`timescale 1ns/1ps
module tb_slope_adc_seq;
    import slope_adc_pkg::*;
    localparam int RAMP = 400;
    localparam int RST  = 40;
    localparam logic [15:0] UNK [3] = '{16'h8c, 16'hf0, 16'h14};
    localparam logic [31:0] EXP [3] = '{32'h5, 32'ha, 32'h0};
    logic        aclk, busy, result_valid, integ_reset, width_in;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic        aresetn = 1'b0, convert = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [4:0]  s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, result;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  source_sel;
    logic [15:0] unk_len = 16'h8c;
    int          errors = 0, comparisons = 0;
    ////////////////////////////////////////////////////////////////////////
    slope_adc_seq #(.RAMP_CYC(RAMP), .RESET_CYC(RST), .AVG_N(1)) DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .convert, .busy, .result_valid,
        .result, .integ_reset, .source_sel, .width_in
    );
    front_end_model fe (
        .aclk, .aresetn, .integ_reset, .source_sel, .unk_len, .width_in
    );
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial begin
        repeat (30000) @(posedge aclk);
        errors++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_write(input logic [4:0] a, input logic [31:0] d);
        bit aw;
        bit w;
        logic [1:0] er;
        aw = 1'b0;
        w = 1'b0;
        er = (a == CTRL_OFS || a == AVG_OFS) ? RESP_OKAY : RESP_SLVERR;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        check({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axi_read(input logic [4:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Start, send a stray command while busy, wait for the end
    task automatic run_conv(input logic [15:0] unk, input bit by_reg,
                            output int cyc);
        unk_len <= unk;
        if (by_reg) begin
            axi_write(CTRL_OFS, 32'h1);
        end else begin
            convert <= 1'b1;
            @(posedge aclk);
            convert <= 1'b0;
            @(posedge aclk);
        end
        cyc = 0;
        check({31'h0, busy}, 32'h1);
        convert <= 1'b1;
        @(posedge aclk);
        convert <= 1'b0;
        while (busy !== 1'b0) begin
            @(posedge aclk);
            cyc++;
        end
        repeat (4) @(posedge aclk);
        check({31'h0, busy}, 32'h0);
        check({31'h0, result_valid}, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] z, f, u, d;
        logic [1:0]  r;
        int          cyc;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3 * RAMP) @(posedge aclk);
        check({31'h0, busy}, 32'h0);
        axi_read(AVG_OFS, d, r);
        check(d, 32'(AVG_RESET));
        axi_read(5'h1c, d, r);
        check(d, 32'h0);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        axi_write(5'h1c, 32'h1);
        check({31'h0, busy}, 32'h0);
        $display("test idle done");
        for (int i = 0; i < 3; i++) begin
            run_conv(UNK[i], i[0], cyc);
            check(result, EXP[i]);
            axi_read(RESULT_OFS, d, r);
            check(d, EXP[i]);
            axi_read(ZERO_OFS, z, r);
            axi_read(FULL_OFS, f, r);
            axi_read(UNK_OFS, u, r);
            check(f - z, 32'hc8);
            check(u - z, 32'(UNK[i]) - 32'h28);
            check({31'h0, cyc < 1800}, 32'h1);
            $display("test convert %0d done", i);
        end
        axi_write(AVG_OFS, 32'h0);
        axi_read(AVG_OFS, d, r);
        check(d, 32'h1);
        axi_write(AVG_OFS, 32'h2);
        run_conv(16'h8c, 1'b0, cyc);
        check(result, 32'h5);
        check({31'h0, cyc > 1800}, 32'h1);
        $display("test average done");
        summarize();
    end
endmodule // tb_slope_adc_seq
